// File: core/exec_map.svh
// register offsets, command fields, reset values and timing counts
// assumes: included by bare name from the core module and the bench module
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

`define REG_CMD 8'h00
`define REG_ACC 8'h04
`define REG_STATUS 8'h08
`define REG_CTRL 8'h0C

`define CMD_LIT_LSB 0
`define CMD_ADDR_LSB 8
`define CMD_BIT_LSB 16
`define CMD_DEST_BIT 20
`define CMD_OP_LSB 24

`define STAT_CARRY 0
`define STAT_NIBBLE 1
`define STAT_ZERO 2
`define STAT_BUSY 3
`define STAT_SKIP 4

`define CTRL_PRESC_TMR 0

`define ACC_RESET 8'h00
`define FLAG_RESET 1'b0
`define CTRL_RESET 1'b0

`define TIMER_ZERO_ADDR 7'h01
`define PCL_ADDR 7'h02

`define OPERAND_PHASE 2'h1
`define LAST_PHASE 2'h3

`endif

// File: core/exec_pkg.sv
// types shared by the execution core and its arithmetic unit
// assumes: nothing outside itself
package exec_pkg;
   typedef enum logic [3:0] {
      OP_NOP = 4'h0,
      OP_ADD_IMM = 4'h1,
      OP_ADD_REG = 4'h2,
      OP_AND_IMM = 4'h3,
      OP_AND_REG = 4'h4,
      OP_BIT_CLR = 4'h5,
      OP_BIT_SET = 4'h6,
      OP_SKIP_ONE = 4'h7,
      OP_SKIP_ZERO = 4'h8
   } op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXEC = 2'h1,
      ST_NOP = 2'h2
   } state_e;
endpackage : exec_pkg

// File: core/alu_if.sv
// operands to and results from the arithmetic unit
// assumes: core drives operands, unit answers combinationally
`timescale 1ns/1ns
interface alu_if;
   import exec_pkg::*;
   logic [7:0] acc;
   logic [7:0] operand;
   op_e op;
   logic [2:0] bit_pos;
   logic [7:0] result;
   logic carry;
   logic nibble;
   logic zero;
   logic bit_val;

   modport core (output acc, operand, op, bit_pos, input result, carry, nibble, zero, bit_val);
   modport alu (input acc, operand, op, bit_pos, output result, carry, nibble, zero, bit_val);
endinterface : alu_if

// File: core/alu_unit.sv
// combinational add, and, bit clear/set and bit test
// assumes: operands come from flip-flops in the core
`timescale 1ns/1ns
module alu_unit
   import exec_pkg::*;
(
   alu_if.alu bus
);
   logic [8:0] sum;
   logic [4:0] low_sum;
   logic [7:0] mask;

   // =========================================
   // arithmetic
   // =========================================
   always_comb begin
      sum = {1'b0, bus.acc} + {1'b0, bus.operand};
      low_sum = {1'b0, bus.acc[3:0]} + {1'b0, bus.operand[3:0]};
      mask = 8'h01 << bus.bit_pos;
      bus.carry = 1'b0;
      bus.nibble = 1'b0;
      case (bus.op)
         OP_ADD_IMM, OP_ADD_REG: begin
            // RULE_14 keep low eight
            bus.result = sum[7:0];
            // RULE_13 carry and nibble
            bus.carry = sum[8];
            bus.nibble = low_sum[4];
         end
         OP_AND_IMM, OP_AND_REG: begin
            bus.result = bus.acc & bus.operand;
         end
         // RULE_08 clear one bit
         OP_BIT_CLR: bus.result = bus.operand & ~mask;
         // RULE_09 set one bit
         OP_BIT_SET: bus.result = bus.operand | mask;
         default: bus.result = bus.operand;
      endcase
      // RULE_13 zero detect
      bus.zero = (bus.result == 8'h00);
      bus.bit_val = bus.operand[bus.bit_pos];
   end
endmodule : alu_unit

// File: core/exec_core.sv
// execution core for add, and, bit clear/set and bit-test-skip instructions
// assumes: file register read data is valid one cycle after file_addr
//
// What this block does
// RULE_01 - modify I/O register using pin levels
// RULE_02 - timer-zero write clears its prescaler
// RULE_03 - skip or PC write adds NOP cycle
// RULE_04 - add immediate into accumulator, flags C,DC,Z
// RULE_05 - add register, destination select, flags C,DC,Z
// RULE_06 - and immediate into accumulator, zero only
// RULE_07 - and register, destination select, zero only
// RULE_08 - bit clear, other bits, flags kept
// RULE_09 - bit set, other bits, flags kept
// RULE_10 - skip next when tested bit one
// RULE_11 - skip next when tested bit zero
// RULE_12 - instruction cycle is four clock periods
// RULE_13 - zero, carry, nibble overflow flag meaning
// RULE_14 - results truncated to eight bits
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`include "exec_map.svh"
module exec_core
   import exec_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   // file register space
   output logic [6:0] file_addr,
   input wire logic [7:0] file_rdata,
   input wire logic [7:0] pin_data,
   input wire logic file_is_io,
   output logic [7:0] file_wdata,
   output logic file_we,
   // timer zero and sequencing
   output logic presc_clr,
   output logic busy,
   output logic [1:0] inst_phase
);
   state_e state_ff;
   logic [1:0] phase_ff;
   op_e op_ff;
   logic [7:0] lit_ff;
   logic [6:0] addr_ff;
   logic [2:0] bit_ff;
   logic dest_ff;
   logic [7:0] operand_ff;
   logic [7:0] acc_ff;
   logic carry_ff;
   logic nibble_ff;
   logic zero_ff;
   logic skip_ff;
   logic presc_tmr_ff;
   logic file_we_ff;
   logic [7:0] file_wdata_ff;
   logic presc_clr_ff;
   logic [31:0] rdata_ff;
   logic issue;
   logic write_phase;
   logic uses_lit;
   logic is_add;
   logic is_and;
   logic writes_file;
   logic writes_acc;
   logic skip_taken;
   logic two_cycle;
   logic idle;

   alu_if alu_bus ();

   alu_unit u_alu (
      .bus(alu_bus.alu)
   );

   // =========================================
   // decode
   // =========================================
   assign idle = (state_ff == ST_IDLE);
   assign issue = reg_wr && (reg_addr == `REG_CMD) && idle;
   assign write_phase = (state_ff == ST_EXEC) && (phase_ff == `LAST_PHASE);
   assign uses_lit = (op_ff == OP_ADD_IMM) || (op_ff == OP_AND_IMM);
   assign is_add = (op_ff == OP_ADD_IMM) || (op_ff == OP_ADD_REG);
   assign is_and = (op_ff == OP_AND_IMM) || (op_ff == OP_AND_REG);
   // RULE_05 destination select
   assign writes_file = (((op_ff == OP_ADD_REG) || (op_ff == OP_AND_REG)) && dest_ff)
                        || (op_ff == OP_BIT_CLR) || (op_ff == OP_BIT_SET);
   assign writes_acc = uses_lit || (((op_ff == OP_ADD_REG) || (op_ff == OP_AND_REG)) && !dest_ff);
   // RULE_10 skip when one
   // RULE_11 skip when zero
   assign skip_taken = ((op_ff == OP_SKIP_ONE) && alu_bus.bit_val)
                       || ((op_ff == OP_SKIP_ZERO) && !alu_bus.bit_val);
   // RULE_03 two cycle cases
   assign two_cycle = skip_taken || (writes_file && (addr_ff == `PCL_ADDR));

   assign alu_bus.acc = acc_ff;
   assign alu_bus.operand = uses_lit ? lit_ff : operand_ff;
   assign alu_bus.op = op_ff;
   assign alu_bus.bit_pos = bit_ff;

   // =========================================
   // sequencer
   // =========================================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_ff <= ST_IDLE;
      end else begin
         case (state_ff)
            ST_IDLE: if (issue) state_ff <= ST_EXEC;
            ST_EXEC: begin
               if (phase_ff == `LAST_PHASE) begin
                  // RULE_03 second cycle as NOP
                  state_ff <= two_cycle ? ST_NOP : ST_IDLE;
               end
            end
            ST_NOP: if (phase_ff == `LAST_PHASE) state_ff <= ST_IDLE;
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // RULE_12 four phase counter
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         phase_ff <= 2'h0;
      end else if (idle) begin
         phase_ff <= 2'h0;
      end else begin
         phase_ff <= phase_ff + 2'h1;
      end
   end

   // =========================================
   // instruction fields
   // =========================================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op_ff <= OP_NOP;
         lit_ff <= 8'h00;
         addr_ff <= 7'h00;
         bit_ff <= 3'h0;
         dest_ff <= 1'b0;
      end else if (issue) begin
         op_ff <= op_e'(reg_wdata[`CMD_OP_LSB +: 4]);
         lit_ff <= reg_wdata[`CMD_LIT_LSB +: 8];
         addr_ff <= reg_wdata[`CMD_ADDR_LSB +: 7];
         bit_ff <= reg_wdata[`CMD_BIT_LSB +: 3];
         dest_ff <= reg_wdata[`CMD_DEST_BIT];
      end
   end

   // RULE_01 operand from pins
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         operand_ff <= 8'h00;
      end else if ((state_ff == ST_EXEC) && (phase_ff == `OPERAND_PHASE)) begin
         operand_ff <= file_is_io ? pin_data : file_rdata;
      end
   end

   // =========================================
   // accumulator and flags
   // =========================================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         acc_ff <= `ACC_RESET;
      end else if (write_phase && writes_acc) begin
         // RULE_04 sum to accumulator
         acc_ff <= alu_bus.result;
      end else if (reg_wr && (reg_addr == `REG_ACC) && idle) begin
         acc_ff <= reg_wdata[7:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         carry_ff <= `FLAG_RESET;
         nibble_ff <= `FLAG_RESET;
         zero_ff <= `FLAG_RESET;
      end else if (write_phase && is_add) begin
         // RULE_13 add updates all three
         carry_ff <= alu_bus.carry;
         nibble_ff <= alu_bus.nibble;
         zero_ff <= alu_bus.zero;
      end else if (write_phase && is_and) begin
         // RULE_06 zero only
         zero_ff <= alu_bus.zero;
      end else if (reg_wr && (reg_addr == `REG_STATUS) && idle) begin
         carry_ff <= reg_wdata[`STAT_CARRY];
         nibble_ff <= reg_wdata[`STAT_NIBBLE];
         zero_ff <= reg_wdata[`STAT_ZERO];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         skip_ff <= `FLAG_RESET;
      end else if (write_phase) begin
         skip_ff <= skip_taken;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         presc_tmr_ff <= `CTRL_RESET;
      end else if (reg_wr && (reg_addr == `REG_CTRL)) begin
         presc_tmr_ff <= reg_wdata[`CTRL_PRESC_TMR];
      end
   end

   // =========================================
   // file write and prescaler clear
   // =========================================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         file_we_ff <= 1'b0;
         file_wdata_ff <= 8'h00;
         presc_clr_ff <= 1'b0;
      end else begin
         // RULE_07 result to register
         file_we_ff <= write_phase && writes_file;
         if (write_phase && writes_file) begin
            file_wdata_ff <= alu_bus.result;
         end
         // RULE_02 clear timer prescaler
         presc_clr_ff <= write_phase && writes_file && (addr_ff == `TIMER_ZERO_ADDR) && presc_tmr_ff;
      end
   end

   // =========================================
   // register read
   // =========================================
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata_ff <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `REG_ACC: rdata_ff <= {24'h000000, acc_ff};
            `REG_STATUS: rdata_ff <= {27'h0, skip_ff, !idle, zero_ff, nibble_ff, carry_ff};
            `REG_CTRL: rdata_ff <= {31'h0, presc_tmr_ff};
            default: rdata_ff <= 32'h0000_0000;
         endcase
      end else begin
         rdata_ff <= 32'h0000_0000;
      end
   end

   assign reg_rdata = rdata_ff;
   assign file_addr = addr_ff;
   assign file_wdata = file_wdata_ff;
   assign file_we = file_we_ff;
   assign presc_clr = presc_clr_ff;
   assign busy = !idle;
   assign inst_phase = phase_ff;

   // =========================================
   // assertions
   // =========================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   AST_PHASE_STEP: assert property ( // RULE_12
      (issue ##1 1) |-> (phase_ff == 2'h0) ##1 (phase_ff == 2'h1) ##1 (phase_ff == 2'h2) ##1 (phase_ff == 2'h3)
   ) else $error("instruction cycle is not four clocks");

   AST_NOP_CYCLE: assert property ( // RULE_03
      (write_phase && two_cycle) |=> (state_ff == ST_NOP)[*4] ##1 (state_ff == ST_IDLE)
   ) else $error("second cycle not a four clock nop");

   AST_ONE_CYCLE: assert property ( // RULE_03
      (write_phase && !two_cycle) |=> (state_ff == ST_IDLE)
   ) else $error("single cycle instruction overran");

   AST_PIN_OPERAND: assert property ( // RULE_01
      ((state_ff == ST_EXEC) && (phase_ff == `OPERAND_PHASE) && file_is_io) |=> (operand_ff == $past(pin_data))
   ) else $error("io operand not taken from pins");

   AST_PRESC_CLR: assert property ( // RULE_02
      (write_phase && writes_file && (addr_ff == `TIMER_ZERO_ADDR) && presc_tmr_ff) |=> (presc_clr && file_we)
   ) else $error("prescaler not cleared on timer write");

   AST_NO_PRESC_CLR: assert property ( // RULE_02
      presc_clr |-> $past(presc_tmr_ff) && file_we && (file_addr == `TIMER_ZERO_ADDR)
   ) else $error("spurious prescaler clear");

   AST_ADD_IMM: assert property ( // RULE_04
      (write_phase && (op_ff == OP_ADD_IMM)) |=> (acc_ff == 8'($past(acc_ff) + $past(lit_ff)))
   ) else $error("add immediate sum wrong");

   AST_ADD_CARRY: assert property ( // RULE_13
      (write_phase && is_add) |=> (carry_ff == ($past({1'b0, acc_ff}) + $past({1'b0, alu_bus.operand}) > 9'h0FF))
   ) else $error("carry flag wrong");

   AST_ADD_DEST: assert property ( // RULE_05
      (write_phase && (op_ff == OP_ADD_REG) && dest_ff) |=> file_we && $stable(acc_ff)
   ) else $error("add register destination wrong");

   AST_AND_IMM: assert property ( // RULE_06
      (write_phase && (op_ff == OP_AND_IMM)) |=> (acc_ff == ($past(acc_ff) & $past(lit_ff))) && $stable(carry_ff)
   ) else $error("and immediate wrong");

   AST_AND_REG: assert property ( // RULE_07
      (write_phase && (op_ff == OP_AND_REG) && !dest_ff) |=> !file_we && (zero_ff == (acc_ff == 8'h00))
   ) else $error("and register destination or zero wrong");

   AST_BIT_CLR: assert property ( // RULE_08
      (write_phase && (op_ff == OP_BIT_CLR)) |=> file_we && !file_wdata[$past(bit_ff)] && $stable(zero_ff)
   ) else $error("bit clear wrong");

   AST_BIT_SET: assert property ( // RULE_09
      (write_phase && (op_ff == OP_BIT_SET)) |=> file_we && file_wdata[$past(bit_ff)] && $stable(carry_ff)
   ) else $error("bit set wrong");

   AST_SKIP_ONE: assert property ( // RULE_10
      (write_phase && (op_ff == OP_SKIP_ONE) && operand_ff[bit_ff]) |=> (state_ff == ST_NOP) && $stable(zero_ff)
   ) else $error("skip if one did not skip");

   AST_SKIP_ZERO: assert property ( // RULE_11
      (write_phase && (op_ff == OP_SKIP_ZERO) && operand_ff[bit_ff]) |=> (state_ff == ST_IDLE)
   ) else $error("skip if zero skipped on one");

   AST_TRUNC: assert property ( // RULE_14
      (write_phase && (op_ff == OP_ADD_REG) && !dest_ff) |=> (acc_ff == 8'($past(acc_ff) + $past(operand_ff)))
   ) else $error("add register result wrong");

   AST_ADD_FILE: assert property ( // RULE_05
      (write_phase && (op_ff == OP_ADD_REG) && dest_ff) |=> (file_wdata == 8'($past(acc_ff) + $past(operand_ff)))
   ) else $error("add register sum to file wrong");

   AST_AND_FILE: assert property ( // RULE_07
      (write_phase && (op_ff == OP_AND_REG) && dest_ff) |=> file_we && $stable(acc_ff)
         && (file_wdata == ($past(acc_ff) & $past(operand_ff)))
   ) else $error("and register to file wrong");

   AST_SKIP_ZERO_TAKEN: assert property ( // RULE_11
      (write_phase && (op_ff == OP_SKIP_ZERO) && !operand_ff[bit_ff]) |=> (state_ff == ST_NOP) && $stable(carry_ff)
   ) else $error("skip if zero did not skip");

   AST_BIT_KEEP: assert property ( // RULE_08
      (write_phase && ((op_ff == OP_BIT_CLR) || (op_ff == OP_BIT_SET)))
         |=> (((file_wdata ^ $past(operand_ff)) & ~(8'h01 << $past(bit_ff))) == 8'h00)
   ) else $error("bit operation changed other bits");

   COV_SKIP: cover property (write_phase && skip_taken);
   COV_TIMER: cover property (presc_clr);
   COV_CARRY: cover property (write_phase && is_add && alu_bus.carry);
   COV_IO: cover property ((phase_ff == `OPERAND_PHASE) && file_is_io && (state_ff == ST_EXEC));
   COV_PCL: cover property (write_phase && writes_file && (addr_ff == `PCL_ADDR));
endmodule : exec_core

// File: sim/tb_mcu_core_alu_bit_ops.sv
// self-checking bench for the execution core: register port, file space, model
// assumes: exec_core carries its own assertions; bench answers file reads from memory
`timescale 1ns/1ns
`include "exec_map.svh"
module tb_mcu_core_alu_bit_ops
   import exec_pkg::*;
;
   // ========================================
   // signals and model state
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic [6:0] file_addr;
   logic [7:0] file_rdata = 8'h00;
   logic [7:0] pin_data = 8'h00;
   logic file_is_io = 1'b0;
   logic [7:0] file_wdata;
   logic file_we;
   logic presc_clr;
   logic busy;
   logic [1:0] inst_phase;
   int n_fail = 0;
   int samples_checked = 0;
   logic [7:0] mem [128];
   logic [7:0] pin_xor = 8'h00;
   logic [7:0] acc = 8'h00;
   logic carry = 1'b0;
   logic nibble = 1'b0;
   logic zero = 1'b0;
   logic last_skip = 1'b0;
   logic ctrl = 1'b0;
   logic [7:0] exp_q [$];

   always #2 clk = ~clk;

   exec_core u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .file_addr(file_addr), .file_rdata(file_rdata),
      .pin_data(pin_data), .file_is_io(file_is_io), .file_wdata(file_wdata), .file_we(file_we),
      .presc_clr(presc_clr), .busy(busy), .inst_phase(inst_phase));

   // ========================================
   // file space: addresses 4..7 are io, their pins differ from the latch
   always @(posedge clk) begin
      file_rdata <= mem[file_addr];
      pin_data <= mem[file_addr] ^ pin_xor;
      file_is_io <= (file_addr[6:2] == 5'h01);
   end

   // ========================================
   // tasks
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : rd

   task automatic run(input logic [3:0] op, input logic [7:0] lit, input logic [6:0] a, input logic [2:0] b,
                      input logic d, input logic poke);
      logic [7:0] opnd;
      logic [7:0] res;
      logic wr_f;
      logic skip;
      logic [31:0] rv;
      int sum;
      int nb;
      opnd = (a[6:2] == 5'h01) ? (mem[a] ^ pin_xor) : mem[a];
      if (op == OP_ADD_IMM || op == OP_AND_IMM) begin
         opnd = lit;
      end
      res = 8'h00;
      wr_f = 1'b0;
      skip = 1'b0;
      case (op)
         OP_ADD_IMM, OP_ADD_REG: begin
            sum = acc + opnd;
            nb = acc[3:0] + opnd[3:0];
            res = sum[7:0];
            carry = sum > 255;
            nibble = nb > 15;
            zero = (res == 8'h00);
            wr_f = (op == OP_ADD_REG) && d;
         end
         OP_AND_IMM, OP_AND_REG: begin
            res = acc & opnd;
            zero = (res == 8'h00);
            wr_f = (op == OP_AND_REG) && d;
         end
         OP_BIT_CLR: begin
            res = opnd & ~(8'h01 << b);
            wr_f = 1'b1;
         end
         OP_BIT_SET: begin
            res = opnd | (8'h01 << b);
            wr_f = 1'b1;
         end
         OP_SKIP_ONE: skip = opnd[b];
         OP_SKIP_ZERO: skip = !opnd[b];
         default: ;
      endcase
      if (op >= OP_ADD_IMM && op <= OP_AND_REG && !wr_f) begin
         acc = res;
      end
      if (op == OP_SKIP_ONE || op == OP_SKIP_ZERO) begin
         last_skip = skip;
      end
      if (wr_f) begin
         exp_q.push_back(res);
      end
      nb = (skip || (wr_f && a == `PCL_ADDR)) ? 8 : 4;
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= `REG_CMD;
      reg_wdata <= {4'h0, op, 3'h0, d, 1'b0, b, 1'b0, a, lit};
      // k counts the cycles after the edge that takes the command
      for (int k = 0; k <= 8; k++) begin
         @(posedge clk);
         // accumulator and command writes while busy must be ignored
         if (poke && k == 2) begin
            reg_wr <= 1'b1;
            reg_addr <= lit[0] ? `REG_ACC : `REG_CMD;
            reg_wdata <= ~reg_wdata;
         end else begin
            reg_wr <= 1'b0;
         end
         #1;
         check("busy", busy, k < nb);
         check("phase", inst_phase, (k < nb) ? k % 4 : 0);
         check("file address", file_addr, a);
         check("file write", file_we, k == 4 && wr_f);
         check("prescaler clear", presc_clr, k == 4 && wr_f && a == `TIMER_ZERO_ADDR && ctrl);
         if (k == 4 && wr_f) begin
            check("file data", file_wdata, exp_q.pop_front());
            mem[a] = res;
         end
      end
      rd(`REG_ACC, rv);
      check("acc", rv, acc);
      rd(`REG_STATUS, rv);
      check("flags", rv[3:0], {1'b0, zero, nibble, carry});
      if (op == OP_SKIP_ONE || op == OP_SKIP_ZERO) begin
         check("skip taken", rv[4], last_skip);
      end
   endtask : run

   task automatic results();
      $display("checked %0d samples, %0d failures", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results

   // ========================================
   // main sequence
   initial begin
      logic [31:0] rv;
      logic [7:0] da [4];
      logic [7:0] dl [4];
      logic [3:0] dop [4];
      logic [3:0] op;
      logic [6:0] a;
      int sel;
      da = '{8'hFF, 8'h0F, 8'hF0, 8'h80};
      dl = '{8'h01, 8'h01, 8'h0F, 8'h80};
      dop = '{OP_ADD_IMM, OP_ADD_IMM, OP_AND_IMM, OP_ADD_IMM};
      void'($urandom(46));
      for (int i = 0; i < 128; i++) begin
         mem[i] = 8'($urandom);
      end
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(`REG_ACC, rv);
      check("acc reset", rv, 32'h0);
      rd(`REG_STATUS, rv);
      check("status reset", rv, 32'h0);
      rd(8'h10, rv);
      check("unmapped read", rv, 32'h0);
      ctrl = 1'b1;
      wr(`REG_CTRL, {31'h0, ctrl});
      rd(`REG_CTRL, rv);
      check("ctrl", rv, 32'h1);
      // carry, nibble and zero boundaries
      for (int i = 0; i < 4; i++) begin
         acc = da[i];
         wr(`REG_ACC, {24'h0, acc});
         run(dop[i], dl[i], 7'h10, 3'h0, 1'b0, 1'b0);
      end
      for (int i = 0; i < 400; i++) begin
         sel = $urandom_range(3, 0);
         a = (sel == 0) ? `TIMER_ZERO_ADDR : (sel == 1) ? `PCL_ADDR : (sel == 2) ? 7'(4 + i % 4) : 7'($urandom);
         op = 4'($urandom_range(10, 0));
         pin_xor = 8'($urandom);
         ctrl = 1'($urandom);
         wr(`REG_CTRL, {31'h0, ctrl});
         if (i % 8 == 0) begin
            acc = 8'($urandom);
            {zero, nibble, carry} = 3'($urandom);
            wr(`REG_ACC, {24'h0, acc});
            wr(`REG_STATUS, {29'h0, zero, nibble, carry});
         end
         run(op, 8'($urandom), a, 3'($urandom), 1'($urandom), 1'($urandom));
      end
      results();
   end
endmodule : tb_mcu_core_alu_bit_ops
